// ==== tb/pwm_fault_lock_timebase_ctrl_tb.sv ====
// self-checking bench for the pwm fault, lock and time-base block
`timescale 1ns/1ps
module pwm_fault_lock_timebase_ctrl_tb;
    logic ref_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic cpu_idle_i = 1'b0;
    logic ack = 1'b0;
    logic flt = 1'b0;
    logic srun = 1'b0;
    logic wpc = 1'b1;
    logic [3:0] reg_addr_i = 4'h0;
    logic [15:0] reg_wdata_i = 16'h0000;
    logic [15:0] rdata, rdv, oc, cnt, m;
    logic fpin, spin, sout, soe, trig, irq, safe, run;
    logic [3:0] pss [3] = '{4'h0, 4'h1, 4'hf};
    int miscompares = 0;
    int comparisons = 0;
    int cycles = 0;
    int c;

    pwm_fault_lock_timebase_ctrl dut (.ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i), .reg_rdata_o(rdata), .cpu_idle_i(cpu_idle_i),
        .write_protect_config_bit_i(wpc), .special_event_ack_i(ack),
        .class_b_fault_input_i(fpin), .external_sync_input_i(spin),
        .sync_output_pin_o(sout), .sync_output_oe_o(soe),
        .special_event_trigger_o(trig), .special_event_irq_o(irq),
        .pwm_safe_o(safe), .pwm_run_o(run), .time_base_count_o(cnt),
        .output_control_o(oc));
    pwm_pin_partner peer (.ref_clk_i(ref_clk_i), .fault_drive_i(flt),
        .sync_run_i(srun), .sync_low_i(1'b0), .fault_pin_o(fpin),
        .sync_pin_o(spin));

    initial forever #12.5 ref_clk_i = ~ref_clk_i;

    task automatic chk(input string n, input logic [15:0] s, e);
        comparisons++;
        if (s !== e) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask
    // one assignment per signal per edge, so accesses may run back to back
    task automatic acc(input logic w, r, input logic [3:0] a,
                       input logic [15:0] d);
        @(posedge ref_clk_i);
        reg_wr_i <= w;
        reg_rd_i <= r;
        reg_addr_i <= a;
        reg_wdata_i <= d;
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        acc(1'b1, 1'b0, a, d);
        acc(1'b0, 1'b0, 4'h0, 16'h0000);
        #1;
    endtask
    task automatic rd(input logic [3:0] a);
        acc(1'b0, 1'b1, a, 16'h0000);
        acc(1'b0, 1'b0, 4'h0, 16'h0000);
        #1 rdv = rdata;
    endtask
    task automatic unlock(input logic [3:0] a, input logic [15:0] d);
        acc(1'b1, 1'b0, 4'h3, 16'habcd);
        acc(1'b1, 1'b0, 4'h3, 16'h4321);
        wr(a, d);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk_i);
        #1;
    endtask
    // cycles in a window where the chosen output sits at a level
    task automatic tally(input int sel, input logic lvl, input int n);
        c = 0;
        repeat (n) begin
            cyc(1);
            if (((sel == 0) ? trig : sout) === lvl) c++;
        end
    endtask
    task automatic peak(input int n);
        m = 16'h0000;
        repeat (n) begin
            cyc(1);
            if (cnt > m) m = cnt;
        end
    endtask
    task automatic finish_test;
        if (miscompares == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // hang guard, far above the roughly eleven hundred cycles the tests need
    always @(posedge ref_clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            finish_test;
        end
    end

    initial begin
        repeat (12) @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        rd(4'h0);
        chk("tb_ctrl", rdv, 16'h0000);
        chk("safe", {15'h0, safe}, 16'h0001);
        rd(4'h6);
        chk("status", rdv, 16'h0007);
        wr(4'h4, 16'h00ff);
        chk("out_locked", oc, 16'h0000);
        unlock(4'h4, 16'h5a5a);
        chk("out_open", oc, 16'h5a5a);
        rd(4'h6);
        chk("rearm", rdv, 16'h0007);
        wr(4'h4, 16'h1111);
        chk("out_once", oc, 16'h5a5a);
        // a read slipped between the keys must spoil the sequence
        acc(1'b1, 1'b0, 4'h3, 16'habcd);
        acc(1'b0, 1'b1, 4'h0, 16'h0000);
        acc(1'b1, 1'b0, 4'h3, 16'h4321);
        wr(4'h4, 16'h2222);
        chk("out_broken", oc, 16'h5a5a);
        acc(1'b1, 1'b0, 4'h3, 16'habcd);
        acc(1'b1, 1'b0, 4'h3, 16'h1234);
        wr(4'h4, 16'h3333);
        chk("out_badkey", oc, 16'h5a5a);
        flt <= 1'b1;
        unlock(4'h5, 16'h0001);
        cyc(4);
        chk("cycle_hi", {15'h0, safe}, 16'h0001);
        flt <= 1'b0;
        cyc(4);
        chk("cycle_lo", {15'h0, safe}, 16'h0000);
        unlock(4'h5, 16'h8000);
        cyc(2);
        chk("cleared", {15'h0, safe}, 16'h0000);
        flt <= 1'b1;
        cyc(4);
        flt <= 1'b0;
        cyc(4);
        chk("latched", {15'h0, safe}, 16'h0001);
        // immediate update must be on before the period write lands
        wr(4'h0, 16'h0400);
        wr(4'h1, 16'h0004);
        wr(4'h2, 16'h0002);
        for (int k = 0; k < 3; k++) begin
            wr(4'h0, 16'h0400 | {12'h000, pss[k]});
            wr(4'h0, 16'h8400 | {12'h000, pss[k]});
            cyc(1);
            chk("run", {15'h0, run}, 16'h0001);
            tally(0, 1'b1, 20 * (int'(pss[k]) + 1));
            chk("triggers", 16'(c), 16'h0004);
            chk("irq_off", {15'h0, irq}, 16'h0000);
            wr(4'h0, 16'h0000);
        end
        wr(4'h0, 16'h0c00);
        wr(4'h0, 16'h8c00);
        tally(0, 1'b1, 10);
        cyc(1);
        chk("irq_on", {15'h0, irq}, 16'h0001);
        rd(4'h0);
        chk("pending", rdv, 16'h9c00);
        wr(4'h0, 16'h0000);
        ack <= 1'b1;
        cyc(2);
        ack <= 1'b0;
        rd(4'h0);
        chk("acked", rdv, 16'h0000);
        wr(4'h0, 16'h2400);
        wr(4'h0, 16'ha400);
        cpu_idle_i <= 1'b1;
        cyc(3);
        m = cnt;
        cyc(5);
        chk("idle_hold", cnt, m);
        cpu_idle_i <= 1'b0;
        wr(4'h0, 16'h0000);
        for (int p = 0; p < 2; p++) begin
            wr(4'h0, 16'h0500 | (16'(p) << 9));
            wr(4'h0, 16'h8500 | (16'(p) << 9));
            cyc(1);
            chk("sync_oe", {15'h0, soe}, 16'h0001);
            tally(1, p == 0, 50);
            chk("sync_pulses", 16'(c), 16'h000a);
            wr(4'h0, 16'h0000);
            cyc(1);
            chk("sync_off", {14'h0, soe, sout}, 16'h0000);
        end
        wr(4'h0, 16'h0480);
        wr(4'h1, 16'h0064);
        wr(4'h0, 16'h8480);
        srun <= 1'b1;
        peak(200);
        chk("ext_restart", {15'h0, m < 16'h0032}, 16'h0001);
        wr(4'h0, 16'h0000);
        wr(4'h0, 16'h0490);
        wr(4'h0, 16'h8490);
        peak(250);
        chk("reserved_src", m, 16'h0064);
        srun <= 1'b0;
        wr(4'h0, 16'h0000);
        // second reset with protection strapped off
        wpc <= 1'b0;
        rst_n_i <= 1'b0;
        cyc(3);
        rst_n_i <= 1'b1;
        wr(4'h4, 16'h0bad);
        chk("out_free", oc, 16'h0bad);
        rd(4'h6);
        chk("status_free", rdv, 16'h0003);
        finish_test;
    end
endmodule // pwm_fault_lock_timebase_ctrl_tb

// ==== tb/pwm_pin_partner.sv ====
// pin-side model: directly driven fault source and periodic sync pulser
`timescale 1ns/1ps
module pwm_pin_partner #(
    parameter int SYNC_PERIOD = 40
) (
    input wire logic ref_clk_i,
    input wire logic fault_drive_i,
    input wire logic sync_run_i,
    input wire logic sync_low_i,
    output logic fault_pin_o,
    output logic sync_pin_o
);
    int ph = 0;
    // the fault line follows the drive input directly, with no pull-down
    assign fault_pin_o = fault_drive_i;
    // two-cycle pulse so the pin synchroniser never misses it
    assign sync_pin_o = sync_low_i ^ (sync_run_i && ph < 2);
    // pulse period kept shorter than the 100-count period of the external restart test
    always @(posedge ref_clk_i) begin
        ph <= (sync_run_i && ph < SYNC_PERIOD - 1) ? ph + 1 : 0;
    end
endmodule // pwm_pin_partner

// ==== verilog/pwm_ctrl_pkg.sv ====
// constants, register map and types of the pwm fault, lock and time-base block
package pwm_ctrl_pkg;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;

    // register word offsets
    localparam logic [3:0] OFS_TB_CTRL = 4'h0;
    localparam logic [3:0] OFS_PERIOD = 4'h1;
    localparam logic [3:0] OFS_SEV_CMP = 4'h2;
    localparam logic [3:0] OFS_KEY = 4'h3;
    localparam logic [3:0] OFS_OUT_CTRL = 4'h4;
    localparam logic [3:0] OFS_FAULT_CTRL = 4'h5;
    localparam logic [3:0] OFS_STATUS = 4'h6;

    // time-base control field positions
    localparam int TB_MODULE_ENABLE = 15;
    localparam int TB_IDLE_STOP = 13;
    localparam int TB_SE_PENDING = 12;
    localparam int TB_SE_IRQ_EN = 11;
    localparam int TB_IMM_PERIOD = 10;
    localparam int TB_SYNC_POL = 9;
    localparam int TB_SYNC_OEN = 8;
    localparam int TB_EXT_SYNC_EN = 7;
    localparam int TB_SRC_HI = 6;
    localparam int TB_SRC_LO = 4;
    localparam int TB_PS_HI = 3;
    localparam int TB_PS_LO = 0;
    localparam logic [15:0] TB_WR_MASK = 16'hafff;
    localparam logic [2:0] SRC_SYNC_PIN = 3'h0;

    // fault control layout
    localparam int FC_CLEAR = 15;
    localparam int FC_MODE_HI = 1;
    localparam int FC_MODE_LO = 0;
    localparam logic [1:0] FMODE_LATCHED = 2'h0;
    localparam logic [1:0] FMODE_CYCLE = 2'h1;

    // reset values
    localparam logic [15:0] RST_TB_CTRL = 16'h0000;
    localparam logic [15:0] RST_PERIOD = 16'hfff8;
    localparam logic [15:0] RST_SEV_CMP = 16'h0000;
    localparam logic [15:0] RST_OUT_CTRL = 16'h0000;
    localparam logic [15:0] RST_FAULT_CTRL = 16'h0000;
    localparam logic [15:0] ZERO_WORD = 16'h0000;
    localparam logic [15:0] ONE_WORD = 16'h0001;
    localparam logic [3:0] ZERO_NIB = 4'h0;
    localparam logic [3:0] ONE_NIB = 4'h1;

    // unlock keys
    localparam logic [15:0] UNLOCK_KEY1 = 16'habcd;
    localparam logic [15:0] UNLOCK_KEY2 = 16'h4321;

    typedef enum logic [1:0] {
        LOCK_ARMED = 2'b00,
        LOCK_KEY1_SEEN = 2'b01,
        LOCK_OPEN = 2'b11
    } lock_state_t;
endpackage

// ==== verilog/pwm_fault_lock_timebase_ctrl.sv ====
// fault latch, register write lock and primary time base of the pwm unit
//
// Implementation choices: the register offsets and strobed register access.
`timescale 1ns/1ps
module pwm_fault_lock_timebase_ctrl (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic [3:0] reg_addr_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [15:0] reg_rdata_o,
    input wire logic cpu_idle_i,
    input wire logic write_protect_config_bit_i,
    input wire logic special_event_ack_i,
    input wire logic class_b_fault_input_i,
    input wire logic external_sync_input_i,
    output logic sync_output_pin_o,
    output logic sync_output_oe_o,
    output logic special_event_trigger_o,
    output logic special_event_irq_o,
    output logic pwm_safe_o,
    output logic pwm_run_o,
    output logic [15:0] time_base_count_o,
    output logic [15:0] output_control_o
);
    // address match, shared by the write and read decode
    function automatic logic hit(input logic [3:0] addr,
                                 input logic [3:0] ofs);
        hit = (addr == ofs);
    endfunction

    logic [15:0] tb_ctrl_q;
    logic [15:0] period_buf_q;
    logic [15:0] active_period_q;
    logic [15:0] active_period_d;
    logic [15:0] sev_cmp_q;
    logic [15:0] out_ctrl_q;
    logic [15:0] fault_ctrl_q;
    logic [15:0] count_q;
    logic [15:0] count_d;
    logic [3:0] ps_cnt_q;
    logic [3:0] ps_cnt_d;
    logic pending_q;
    logic pending_d;
    logic fault_latched_q;
    logic fault_latched_d;
    logic lock_cfg_q;
    logic sync_lvl_q;
    logic [15:0] rd_word;

    // decoded strobes
    logic wr_tb;
    logic wr_period;
    logic wr_sev;
    logic wr_key;
    logic wr_out;
    logic wr_fault;
    logic prot_wr;
    logic grant;
    logic lock_open;
    assign wr_tb = reg_wr_i && hit(reg_addr_i, pwm_ctrl_pkg::OFS_TB_CTRL);
    assign wr_period = reg_wr_i && hit(reg_addr_i, pwm_ctrl_pkg::OFS_PERIOD);
    assign wr_sev = reg_wr_i && hit(reg_addr_i, pwm_ctrl_pkg::OFS_SEV_CMP);
    assign wr_key = reg_wr_i && hit(reg_addr_i, pwm_ctrl_pkg::OFS_KEY);
    assign wr_out = reg_wr_i && hit(reg_addr_i, pwm_ctrl_pkg::OFS_OUT_CTRL);
    assign wr_fault = reg_wr_i
        && hit(reg_addr_i, pwm_ctrl_pkg::OFS_FAULT_CTRL);
    assign prot_wr = wr_out || wr_fault;

    unlock_seq u_unlock (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .access_i(reg_wr_i || reg_rd_i),
        .key_wr_i(wr_key),
        .key_data_i(reg_wdata_i),
        .prot_wr_i(prot_wr),
        .lock_cfg_i(lock_cfg_q),
        .grant_o(grant),
        .open_o(lock_open)
    );

    // pins cross into the clock domain before anything reads them
    logic fault_pin_s;
    logic sync_pin_s;
    sync2 #(.WIDTH(2)) u_pin_sync (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .async_i({class_b_fault_input_i, external_sync_input_i}),
        .sync_o({fault_pin_s, sync_pin_s})
    );

    // control fields
    logic module_enable;
    logic idle_stop;
    logic irq_enable;
    logic imm_period;
    logic sync_pol;
    logic sync_oen;
    logic ext_sync_en;
    logic [2:0] sync_src;
    logic [3:0] postscale;
    logic [1:0] fault_mode;
    assign module_enable = tb_ctrl_q[pwm_ctrl_pkg::TB_MODULE_ENABLE];
    assign idle_stop = tb_ctrl_q[pwm_ctrl_pkg::TB_IDLE_STOP];
    assign irq_enable = tb_ctrl_q[pwm_ctrl_pkg::TB_SE_IRQ_EN];
    assign imm_period = tb_ctrl_q[pwm_ctrl_pkg::TB_IMM_PERIOD];
    assign sync_pol = tb_ctrl_q[pwm_ctrl_pkg::TB_SYNC_POL];
    assign sync_oen = tb_ctrl_q[pwm_ctrl_pkg::TB_SYNC_OEN];
    assign ext_sync_en = tb_ctrl_q[pwm_ctrl_pkg::TB_EXT_SYNC_EN];
    assign sync_src = tb_ctrl_q[pwm_ctrl_pkg::TB_SRC_HI:pwm_ctrl_pkg::TB_SRC_LO];
    assign postscale = tb_ctrl_q[pwm_ctrl_pkg::TB_PS_HI:pwm_ctrl_pkg::TB_PS_LO];
    assign fault_mode =
        fault_ctrl_q[pwm_ctrl_pkg::FC_MODE_HI:pwm_ctrl_pkg::FC_MODE_LO];

    // time base: halts in idle, restarts on sync or period match
    logic advance;
    logic sync_lvl;
    logic sync_edge;
    logic ext_restart;
    logic wrap;
    logic restart;
    logic sev_match;
    logic trigger;
    assign advance = module_enable && !(idle_stop && cpu_idle_i);
    assign sync_lvl = sync_pin_s ^ sync_pol;
    assign sync_edge = sync_lvl && !sync_lvl_q;
    // reserved source codes select nothing
    assign ext_restart = module_enable && ext_sync_en
        && (sync_src == pwm_ctrl_pkg::SRC_SYNC_PIN) && sync_edge;
    assign wrap = advance && (count_q >= active_period_q);
    assign restart = wrap || ext_restart;
    assign sev_match = advance && (count_q == sev_cmp_q);
    assign trigger = sev_match && (ps_cnt_q == postscale);

    assign count_d = !module_enable ? pwm_ctrl_pkg::ZERO_WORD
        : restart ? pwm_ctrl_pkg::ZERO_WORD
        : advance ? count_q + pwm_ctrl_pkg::ONE_WORD
        : count_q;
    assign ps_cnt_d = !module_enable ? pwm_ctrl_pkg::ZERO_NIB
        : trigger ? pwm_ctrl_pkg::ZERO_NIB
        : sev_match ? ps_cnt_q + pwm_ctrl_pkg::ONE_NIB
        : ps_cnt_q;
    // immediate load bypasses the buffer; otherwise wait for a restart
    assign active_period_d = (wr_period && imm_period) ? reg_wdata_i
        : restart ? period_buf_q
        : active_period_q;
    // a new event wins over the acknowledge in the same cycle
    assign pending_d = (trigger && irq_enable)
        || (pending_q && !special_event_ack_i);

    // fault: latched mode holds until software clears with the pin low
    logic fault_clear;
    logic safe_d;
    assign fault_clear = wr_fault && grant
        && reg_wdata_i[pwm_ctrl_pkg::FC_CLEAR];
    assign fault_latched_d = (fault_mode == pwm_ctrl_pkg::FMODE_LATCHED)
        && (fault_pin_s || (fault_latched_q && !fault_clear));
    assign safe_d = fault_latched_d
        || ((fault_mode == pwm_ctrl_pkg::FMODE_CYCLE) && fault_pin_s);

    // time base and event state
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            count_q <= pwm_ctrl_pkg::ZERO_WORD;
            ps_cnt_q <= pwm_ctrl_pkg::ZERO_NIB;
            active_period_q <= pwm_ctrl_pkg::RST_PERIOD;
            pending_q <= 1'b0;
            sync_lvl_q <= 1'b0;
        end else begin
            count_q <= count_d;
            ps_cnt_q <= ps_cnt_d;
            active_period_q <= active_period_d;
            pending_q <= pending_d;
            sync_lvl_q <= sync_lvl;
        end
    end

    // config strap is caught while reset is held, then frozen
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            lock_cfg_q <= write_protect_config_bit_i;
        end
    end

    // software registers; protected ones only take granted writes
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            tb_ctrl_q <= pwm_ctrl_pkg::RST_TB_CTRL;
            period_buf_q <= pwm_ctrl_pkg::RST_PERIOD;
            sev_cmp_q <= pwm_ctrl_pkg::RST_SEV_CMP;
            out_ctrl_q <= pwm_ctrl_pkg::RST_OUT_CTRL;
            fault_ctrl_q <= pwm_ctrl_pkg::RST_FAULT_CTRL;
            fault_latched_q <= 1'b1;
        end else begin
            fault_latched_q <= fault_latched_d;
            if (wr_tb) begin
                tb_ctrl_q <= reg_wdata_i & pwm_ctrl_pkg::TB_WR_MASK;
            end
            if (wr_period) begin
                period_buf_q <= reg_wdata_i;
            end
            if (wr_sev) begin
                sev_cmp_q <= reg_wdata_i;
            end
            if (wr_out && grant) begin
                out_ctrl_q <= reg_wdata_i;
            end
            // mode field does not look at the fault pin level
            if (wr_fault && grant) begin
                fault_ctrl_q <= reg_wdata_i;
            end
        end
    end

    // read mux; write-only key and unmapped words read zero
    logic [15:0] tb_read;
    logic [15:0] status_word;
    assign tb_read = tb_ctrl_q
        | ({15'h0000, pending_q} << pwm_ctrl_pkg::TB_SE_PENDING);
    assign status_word = {12'h000, fault_pin_s, lock_cfg_q, !lock_open,
                          fault_latched_q};
    assign rd_word =
        hit(reg_addr_i, pwm_ctrl_pkg::OFS_TB_CTRL) ? tb_read
        : hit(reg_addr_i, pwm_ctrl_pkg::OFS_PERIOD) ? period_buf_q
        : hit(reg_addr_i, pwm_ctrl_pkg::OFS_SEV_CMP) ? sev_cmp_q
        : hit(reg_addr_i, pwm_ctrl_pkg::OFS_OUT_CTRL) ? out_ctrl_q
        : hit(reg_addr_i, pwm_ctrl_pkg::OFS_FAULT_CTRL) ? fault_ctrl_q
        : hit(reg_addr_i, pwm_ctrl_pkg::OFS_STATUS) ? status_word
        : pwm_ctrl_pkg::ZERO_WORD;

    // registered outputs; sync pulse marks each time-base restart
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            reg_rdata_o <= pwm_ctrl_pkg::ZERO_WORD;
            sync_output_pin_o <= 1'b0;
            sync_output_oe_o <= 1'b0;
            special_event_trigger_o <= 1'b0;
            special_event_irq_o <= 1'b0;
            pwm_safe_o <= 1'b1;
            pwm_run_o <= 1'b0;
            time_base_count_o <= pwm_ctrl_pkg::ZERO_WORD;
            output_control_o <= pwm_ctrl_pkg::RST_OUT_CTRL;
        end else begin
            reg_rdata_o <= reg_rd_i ? rd_word : pwm_ctrl_pkg::ZERO_WORD;
            sync_output_pin_o <= sync_oen && (restart ^ sync_pol);
            sync_output_oe_o <= sync_oen;
            special_event_trigger_o <= trigger;
            special_event_irq_o <= pending_d;
            pwm_safe_o <= safe_d;
            pwm_run_o <= module_enable;
            time_base_count_o <= count_d;
            output_control_o <= (wr_out && grant) ? reg_wdata_i : out_ctrl_q;
        end
    end

    // checks on the block's own behaviour
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);

    property p_safe_after_reset;
        $past(!rst_n_i) |-> pwm_safe_o && fault_latched_q;
    endproperty
    a_safe_after_reset: assert property (p_safe_after_reset)
        else $error("fault not latched after reset");

    property p_mode_any_pin;
        wr_fault && grant && fault_pin_s
            |=> fault_mode == $past(reg_wdata_i[1:0]);
    endproperty
    a_mode_any_pin: assert property (p_mode_any_pin)
        else $error("fault mode write lost while pin high");

    property p_locked_blocks;
        wr_out && lock_cfg_q && !lock_open |=> $stable(out_ctrl_q);
    endproperty
    a_locked_blocks: assert property (p_locked_blocks)
        else $error("locked output control was written");

    property p_unprotected;
        wr_out && !lock_cfg_q |=> out_ctrl_q == $past(reg_wdata_i);
    endproperty
    a_unprotected: assert property (p_unprotected)
        else $error("write refused with protection off");

    // an open lock at the first key would eat it, so start from closed
    property p_key_unlock;
        !lock_open && wr_key && reg_wdata_i == pwm_ctrl_pkg::UNLOCK_KEY1
            ##1 wr_key && reg_wdata_i == pwm_ctrl_pkg::UNLOCK_KEY2
            ##1 wr_out |=> out_ctrl_q == $past(reg_wdata_i);
    endproperty
    a_key_unlock: assert property (p_key_unlock)
        else $error("key pair did not unlock");

    property p_one_write;
        lock_open && (reg_wr_i || reg_rd_i) |=> !lock_open;
    endproperty
    a_one_write: assert property (p_one_write)
        else $error("lock stayed open after an access");

    property p_disabled_zero;
        !module_enable |=> count_q == pwm_ctrl_pkg::ZERO_WORD && !pwm_run_o;
    endproperty
    a_disabled_zero: assert property (p_disabled_zero)
        else $error("time base moves while disabled");

    property p_idle_halt;
        module_enable && idle_stop && cpu_idle_i && !ext_restart
            |=> $stable(count_q);
    endproperty
    a_idle_halt: assert property (p_idle_halt)
        else $error("time base counted in idle");

    property p_pending;
        trigger && irq_enable |=> pending_q && special_event_irq_o;
    endproperty
    a_pending: assert property (p_pending)
        else $error("special event not pending");

    property p_imm_period;
        wr_period && imm_period |=> active_period_q == $past(reg_wdata_i);
    endproperty
    a_imm_period: assert property (p_imm_period)
        else $error("immediate period not loaded");

    property p_sync_off;
        !sync_oen |=> !sync_output_oe_o && !sync_output_pin_o;
    endproperty
    a_sync_off: assert property (p_sync_off)
        else $error("sync output driven while disabled");

    property p_ext_restart;
        ext_restart |=> count_q == pwm_ctrl_pkg::ZERO_WORD;
    endproperty
    a_ext_restart: assert property (p_ext_restart)
        else $error("external sync did not restart");

    c_unlock: cover property (wr_key ##1 wr_key ##1 wr_out && grant);
    c_trigger: cover property (special_event_trigger_o);
    c_fault_clear: cover property (fault_latched_q ##1 !fault_latched_q);
    c_sync_restart: cover property (ext_restart);
endmodule // pwm_fault_lock_timebase_ctrl

// ==== verilog/sync2.sv ====
// two-flop synchroniser for pins from outside the clock domain
`timescale 1ns/1ps
module sync2 #(
    parameter int WIDTH = 1
) (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    // first stage feeds only the second stage
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= async_i;
            sync_q <= meta_q;
        end
    end

    assign sync_o = sync_q;
endmodule // sync2

// ==== verilog/unlock_seq.sv ====
// key-sequence write-protection state machine for protected registers
`timescale 1ns/1ps
module unlock_seq (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic access_i,
    input wire logic key_wr_i,
    input wire logic [15:0] key_data_i,
    input wire logic prot_wr_i,
    input wire logic lock_cfg_i,
    output logic grant_o,
    output logic open_o
);
    pwm_ctrl_pkg::lock_state_t state_q;
    pwm_ctrl_pkg::lock_state_t state_d;
    logic key1_hit;
    logic key2_hit;

    assign key1_hit = key_wr_i && (key_data_i == pwm_ctrl_pkg::UNLOCK_KEY1);
    assign key2_hit = key_wr_i && (key_data_i == pwm_ctrl_pkg::UNLOCK_KEY2);

    // every access but a repeated first key advances or breaks the sequence; open lasts one access
    always_comb begin
        state_d = state_q;
        if (access_i) begin
            unique case (state_q)
                pwm_ctrl_pkg::LOCK_ARMED:
                    state_d = key1_hit ? pwm_ctrl_pkg::LOCK_KEY1_SEEN
                                       : pwm_ctrl_pkg::LOCK_ARMED;
                pwm_ctrl_pkg::LOCK_KEY1_SEEN: begin
                    if (key2_hit) begin
                        state_d = pwm_ctrl_pkg::LOCK_OPEN;
                    end else if (key1_hit) begin
                        state_d = pwm_ctrl_pkg::LOCK_KEY1_SEEN;
                    end else begin
                        state_d = pwm_ctrl_pkg::LOCK_ARMED;
                    end
                end
                pwm_ctrl_pkg::LOCK_OPEN:
                    state_d = pwm_ctrl_pkg::LOCK_ARMED;
                default:
                    state_d = pwm_ctrl_pkg::LOCK_ARMED;
            endcase
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            state_q <= pwm_ctrl_pkg::LOCK_ARMED;
        end else begin
            state_q <= state_d;
        end
    end

    // with protection strapped on, only the access right after the second key may write
    assign open_o = (state_q == pwm_ctrl_pkg::LOCK_OPEN);
    assign grant_o = prot_wr_i && (!lock_cfg_i || open_o);
endmodule // unlock_seq
